// >>> inc/fkw_pkg.sv
`default_nettype none
package fkw_pkg;
    // Flash geometry
    localparam int ADDR_W = 13;
    localparam int PAGE_W = 9;
    localparam int NUM_BYTES = 8192;
    localparam int PAGE_BYTES = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Key codes, in the order software must write them
    localparam logic [7:0] KEY_FIRST = 8'hA5;
    localparam logic [7:0] KEY_SECOND = 8'hF1;
    // Register offsets (byte addresses)
    localparam logic [7:0] KEY_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // Control field positions
    localparam int CTRL_WE_BIT = 0;
    localparam int CTRL_EE_BIT = 1;
    localparam int CTRL_BLK_BIT = 2;
    // Status field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OPEN_BIT = 1;
    localparam int STAT_DEAD_BIT = 2;
    localparam int STAT_SUPPLY_BIT = 3;
    localparam int STAT_PEND_BIT = 4;
    // Reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Timing: operation times and the clock period
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_NS = 40000;
    localparam int ERASE_TIME_NS = 20000000;
    localparam int PROG_CYCLES =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Key lock states
    typedef enum logic [3:0] {
        FKW_KEY_WAIT1 = 4'b0001,
        FKW_KEY_WAIT2 = 4'b0010,
        FKW_KEY_OPEN = 4'b0100,
        FKW_KEY_DEAD = 4'b1000
    } fkw_key_t;
    // Operation states
    typedef enum logic [1:0] {
        FKW_OP_IDLE = 2'b01,
        FKW_OP_BUSY = 2'b10
    } fkw_op_t;
endpackage : fkw_pkg
`default_nettype wire

// >>> logic/fkw_array.sv
`timescale 1ns/100ps
`default_nettype none
module fkw_array (
    input wire logic ref_clk_i,
    input wire logic prog_i,
    input wire logic erase_i,
    input wire logic [fkw_pkg::ADDR_W-1:0] prog_addr_i,
    input wire logic [15:0] prog_data_i,
    input wire logic [1:0] prog_be_i,
    input wire logic [fkw_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem [fkw_pkg::NUM_BYTES];
    logic [fkw_pkg::ADDR_W-1:0] even_a;
    logic [fkw_pkg::ADDR_W-1:0] odd_a;

    assign even_a = {prog_addr_i[fkw_pkg::ADDR_W-1:1], 1'b0};
    assign odd_a = {prog_addr_i[fkw_pkg::ADDR_W-1:1], 1'b1};

    // Programming only clears bits; erase fills a whole page
    always_ff @(posedge ref_clk_i) begin
        if (erase_i) begin
            for (int i = 0; i < fkw_pkg::PAGE_BYTES; i++) begin
                mem[{prog_addr_i[fkw_pkg::ADDR_W-1:fkw_pkg::PAGE_W],
                     i[fkw_pkg::PAGE_W-1:0]}] <= fkw_pkg::ERASED_BYTE;
            end
        end else if (prog_i) begin
            if (prog_be_i[0]) begin
                mem[even_a] <= mem[even_a] & prog_data_i[7:0];
            end
            if (prog_be_i[1]) begin
                mem[odd_a] <= mem[odd_a] & prog_data_i[15:8];
            end
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : fkw_array
`default_nettype wire

// >>> logic/fkw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module fkw_ctrl #(
    parameter int unsigned PROG_CYCLES = fkw_pkg::PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = fkw_pkg::ERASE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // Move write cycles from the core
    input wire logic xmove_we_i,
    input wire logic [fkw_pkg::ADDR_W-1:0] xmove_addr_i,
    input wire logic [7:0] xmove_data_i,
    // Supply monitor state
    input wire logic supply_monitor_on_i,
    // Program fetch read port
    input wire logic [fkw_pkg::ADDR_W-1:0] fetch_addr_i,
    output logic [7:0] fetch_data_o,
    // Core stall and error reset request
    output logic stall_o,
    output logic flash_error_reset_o,
    // Move writes that target data RAM
    output logic xram_we_o,
    output logic [fkw_pkg::ADDR_W-1:0] xram_addr_o,
    output logic [7:0] xram_data_o
);

    localparam logic [31:0] PROG_LOAD = 32'(PROG_CYCLES - 1);
    localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYCLES - 1);

    // Whole state of the controller
    typedef struct packed {
        fkw_pkg::fkw_key_t key_st;
        fkw_pkg::fkw_op_t op_st;
        logic [31:0] cnt;
        logic wr_en;
        logic er_en;
        logic blk;
        logic even_vld;
        logic [7:0] even_data;
        logic [fkw_pkg::ADDR_W-2:0] even_addr;
        logic [31:0] rdata;
        logic stall;
        logic err_rst;
        logic xram_we;
        logic [fkw_pkg::ADDR_W-1:0] xram_addr;
        logic [7:0] xram_data;
        logic prog;
        logic erase;
        logic [fkw_pkg::ADDR_W-1:0] prog_addr;
        logic [15:0] prog_data;
        logic [1:0] prog_be;
    } fkw_state_t;

    fkw_state_t s_q;
    fkw_state_t s_d;

    logic busy;
    logic key_wr;
    logic ctrl_wr;
    logic flash_wr;
    logic [31:0] stat_word;
    logic [31:0] ctrl_word;
    logic pair_match;

    // Access decode
    assign busy = (s_q.op_st == fkw_pkg::FKW_OP_BUSY);
    assign key_wr = reg_we_i && (reg_addr_i == fkw_pkg::KEY_OFS);
    assign ctrl_wr = reg_we_i && (reg_addr_i == fkw_pkg::CTRL_OFS);
    assign flash_wr = xmove_we_i && s_q.wr_en && !busy;
    assign pair_match = s_q.even_vld &&
        (s_q.even_addr == xmove_addr_i[fkw_pkg::ADDR_W-1:1]);

    // Read views of control and status
    always_comb begin
        ctrl_word = '0;
        ctrl_word[fkw_pkg::CTRL_WE_BIT] = s_q.wr_en;
        ctrl_word[fkw_pkg::CTRL_EE_BIT] = s_q.er_en;
        ctrl_word[fkw_pkg::CTRL_BLK_BIT] = s_q.blk;
        stat_word = '0;
        stat_word[fkw_pkg::STAT_BUSY_BIT] = busy;
        stat_word[fkw_pkg::STAT_OPEN_BIT] =
            (s_q.key_st == fkw_pkg::FKW_KEY_OPEN);
        stat_word[fkw_pkg::STAT_DEAD_BIT] =
            (s_q.key_st == fkw_pkg::FKW_KEY_DEAD);
        stat_word[fkw_pkg::STAT_SUPPLY_BIT] = supply_monitor_on_i;
        stat_word[fkw_pkg::STAT_PEND_BIT] = s_q.even_vld;
    end

    // Next state
    always_comb begin
        s_d = s_q;
        // One-cycle strobes fall by default
        s_d.prog = 1'b0;
        s_d.erase = 1'b0;
        s_d.err_rst = 1'b0;
        s_d.xram_we = 1'b0;

        // Read data stand for the one cycle after the strobe
        s_d.rdata = '0;
        if (reg_re_i) begin
            if (reg_addr_i == fkw_pkg::KEY_OFS) begin
                s_d.rdata = '0;
            end else if (reg_addr_i == fkw_pkg::CTRL_OFS) begin
                s_d.rdata = ctrl_word;
            end else if (reg_addr_i == fkw_pkg::STAT_OFS) begin
                s_d.rdata = stat_word;
            end else begin
                s_d.rdata = '0;
            end
        end

        // Enable bits move only on software writes
        if (ctrl_wr) begin
            s_d.wr_en = reg_wdata_i[fkw_pkg::CTRL_WE_BIT];
            s_d.er_en = reg_wdata_i[fkw_pkg::CTRL_EE_BIT];
            s_d.blk = reg_wdata_i[fkw_pkg::CTRL_BLK_BIT];
        end

        // Key sequence; any time between codes is fine
        if (key_wr) begin
            case (s_q.key_st)
                fkw_pkg::FKW_KEY_WAIT1: begin
                    if (reg_wdata_i[7:0] == fkw_pkg::KEY_FIRST) begin
                        s_d.key_st = fkw_pkg::FKW_KEY_WAIT2;
                    end else begin
                        s_d.key_st = fkw_pkg::FKW_KEY_DEAD;
                    end
                end
                fkw_pkg::FKW_KEY_WAIT2: begin
                    if (reg_wdata_i[7:0] == fkw_pkg::KEY_SECOND) begin
                        s_d.key_st = fkw_pkg::FKW_KEY_OPEN;
                    end else begin
                        s_d.key_st = fkw_pkg::FKW_KEY_DEAD;
                    end
                end
                fkw_pkg::FKW_KEY_OPEN: begin
                    // A third code is out of order
                    s_d.key_st = fkw_pkg::FKW_KEY_DEAD;
                end
                default: begin
                    s_d.key_st = fkw_pkg::FKW_KEY_DEAD;
                end
            endcase
        end

        // Move writes with flash disabled go to data RAM
        if (xmove_we_i && !s_q.wr_en) begin
            s_d.xram_we = 1'b1;
            s_d.xram_addr = xmove_addr_i;
            s_d.xram_data = xmove_data_i;
        end

        // Flash write or erase attempts
        if (flash_wr) begin
            if (!supply_monitor_on_i) begin
                // Monitor off: no change to memory, ask for reset
                s_d.err_rst = 1'b1;
            end else if (s_q.key_st != fkw_pkg::FKW_KEY_OPEN) begin
                s_d.key_st = fkw_pkg::FKW_KEY_DEAD;
            end else begin
                // Every accepted write relocks the keys
                s_d.key_st = fkw_pkg::FKW_KEY_WAIT1;
                if (s_q.er_en) begin
                    // Any address inside the page erases it
                    s_d.erase = 1'b1;
                    s_d.prog_addr = xmove_addr_i;
                    s_d.op_st = fkw_pkg::FKW_OP_BUSY;
                    s_d.cnt = ERASE_LOAD;
                    s_d.stall = 1'b1;
                    s_d.even_vld = 1'b0;
                end else if (!s_q.blk) begin
                    // One byte per move write
                    s_d.prog = 1'b1;
                    s_d.prog_addr = xmove_addr_i;
                    s_d.prog_data = {xmove_data_i, xmove_data_i};
                    s_d.prog_be = {xmove_addr_i[0], !xmove_addr_i[0]};
                    s_d.op_st = fkw_pkg::FKW_OP_BUSY;
                    s_d.cnt = PROG_LOAD;
                    s_d.stall = 1'b1;
                    s_d.even_vld = 1'b0;
                end else if (!xmove_addr_i[0]) begin
                    // Even byte is held until its odd partner
                    s_d.even_vld = 1'b1;
                    s_d.even_data = xmove_data_i;
                    s_d.even_addr = xmove_addr_i[fkw_pkg::ADDR_W-1:1];
                end else begin
                    // Odd byte starts the program, with the held even byte only if it pairs
                    s_d.prog = 1'b1;
                    s_d.prog_addr = xmove_addr_i;
                    s_d.prog_data = {xmove_data_i, s_q.even_data};
                    s_d.prog_be = {1'b1, pair_match};
                    s_d.op_st = fkw_pkg::FKW_OP_BUSY;
                    s_d.cnt = PROG_LOAD;
                    s_d.stall = 1'b1;
                    s_d.even_vld = 1'b0;
                end
            end
        end

        // Internal timer ends the operation by itself
        case (s_q.op_st)
            fkw_pkg::FKW_OP_IDLE: begin
                if (s_d.op_st == fkw_pkg::FKW_OP_IDLE) begin
                    s_d.stall = 1'b0;
                end
            end
            fkw_pkg::FKW_OP_BUSY: begin
                if (s_q.cnt == '0) begin
                    s_d.op_st = fkw_pkg::FKW_OP_IDLE;
                    s_d.stall = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 32'h00000001;
                    s_d.stall = 1'b1;
                end
            end
            default: begin
                s_d.op_st = fkw_pkg::FKW_OP_IDLE;
                s_d.stall = 1'b0;
            end
        endcase
    end

    // State register; reset reopens the key sequence
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q.key_st <= fkw_pkg::FKW_KEY_WAIT1;
            s_q.op_st <= fkw_pkg::FKW_OP_IDLE;
            s_q.cnt <= '0;
            s_q.wr_en <= fkw_pkg::CTRL_RST;
            s_q.er_en <= fkw_pkg::CTRL_RST;
            s_q.blk <= fkw_pkg::CTRL_RST;
            s_q.even_vld <= 1'b0;
            s_q.even_data <= fkw_pkg::BYTE_RST;
            s_q.even_addr <= '0;
            s_q.rdata <= '0;
            s_q.stall <= 1'b0;
            s_q.err_rst <= 1'b0;
            s_q.xram_we <= 1'b0;
            s_q.xram_addr <= '0;
            s_q.xram_data <= fkw_pkg::BYTE_RST;
            s_q.prog <= 1'b0;
            s_q.erase <= 1'b0;
            s_q.prog_addr <= '0;
            s_q.prog_data <= '0;
            s_q.prog_be <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Flash cell array
    fkw_array u_array (
        .ref_clk_i(ref_clk_i),
        .prog_i(s_q.prog),
        .erase_i(s_q.erase),
        .prog_addr_i(s_q.prog_addr),
        .prog_data_i(s_q.prog_data),
        .prog_be_i(s_q.prog_be),
        .rd_addr_i(fetch_addr_i),
        .rd_data_o(fetch_data_o)
    );

    // Outputs straight from the state register
    assign reg_rdata_o = s_q.rdata;
    assign stall_o = s_q.stall;
    assign flash_error_reset_o = s_q.err_rst;
    assign xram_we_o = s_q.xram_we;
    assign xram_addr_o = s_q.xram_addr;
    assign xram_data_o = s_q.xram_data;

endmodule : fkw_ctrl
`default_nettype wire

// >>> bench/fkw_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module fkw_ctrl_assertions #(
    parameter int unsigned PROG_CYCLES = 4,
    parameter int unsigned ERASE_CYCLES = 6
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic xmove_we_i,
    input wire logic [fkw_pkg::ADDR_W-1:0] xmove_addr_i,
    input wire logic [7:0] xmove_data_i,
    input wire logic supply_monitor_on_i,
    input wire logic [fkw_pkg::ADDR_W-1:0] fetch_addr_i,
    input wire logic [7:0] fetch_data_o,
    input wire logic stall_o,
    input wire logic flash_error_reset_o,
    input wire logic xram_we_o,
    input wire logic [fkw_pkg::ADDR_W-1:0] xram_addr_o,
    input wire logic [7:0] xram_data_o
);
    logic [31:0] cnt_q;
    // Length of the current stall
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= stall_o ? cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Error pulse with no operation started
    sequence s_pulse;
        flash_error_reset_o && !stall_o ##1 !flash_error_reset_o && !stall_o;
    endsequence
    sequence s_copy;
        xram_addr_o == $past(xmove_addr_i) && xram_data_o == $past(xmove_data_i);
    endsequence
    stall_len_a: assert property ($fell(stall_o) |->
        cnt_q == PROG_CYCLES || cnt_q == ERASE_CYCLES)
        else $error("stall length wrong");
    stall_cause_a: assert property ($rose(stall_o) |->
        $past(xmove_we_i && supply_monitor_on_i))
        else $error("stall without move write");
    err_cause_a: assert property (flash_error_reset_o |->
        $past(xmove_we_i && !supply_monitor_on_i))
        else $error("error reset without cause");
    err_pulse_a: assert property ($rose(flash_error_reset_o) |-> s_pulse)
        else $error("error reset not a lone pulse");
    ram_copy_a: assert property (xram_we_o |-> $past(xmove_we_i) ##0 s_copy)
        else $error("ram copy wrong");
    ram_excl_a: assert property (xram_we_o |->
        !$rose(stall_o) && !flash_error_reset_o)
        else $error("move write went both ways");
    rd_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    status_sup_a: assert property (reg_re_i &&
        reg_addr_i == fkw_pkg::STAT_OFS |=>
        reg_rdata_o[fkw_pkg::STAT_SUPPLY_BIT] == $past(supply_monitor_on_i))
        else $error("status supply bit wrong");
endmodule : fkw_ctrl_assertions
bind fkw_ctrl fkw_ctrl_assertions #(.PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) u_chk (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .xmove_we_i(xmove_we_i), .xmove_addr_i(xmove_addr_i),
    .xmove_data_i(xmove_data_i), .supply_monitor_on_i(supply_monitor_on_i),
    .fetch_addr_i(fetch_addr_i), .fetch_data_o(fetch_data_o),
    .stall_o(stall_o), .flash_error_reset_o(flash_error_reset_o),
    .xram_we_o(xram_we_o), .xram_addr_o(xram_addr_o),
    .xram_data_o(xram_data_o));
`default_nettype wire

// >>> bench/fkw_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module fkw_core_model (
    input wire logic ref_clk_i,
    input wire logic stall_i,
    input wire logic err_i,
    input wire logic [31:0] rdata_i,
    input wire logic [7:0] fdata_i,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic we_o,
    output logic re_o,
    output logic mv_o,
    output logic [fkw_pkg::ADDR_W-1:0] mv_addr_o,
    output logic [7:0] mv_data_o,
    output logic sup_o,
    output logic [fkw_pkg::ADDR_W-1:0] faddr_o
);
    // Idle bus, monitor switched on at start
    initial begin
        {addr_o, wdata_o, we_o, re_o, mv_o, mv_addr_o, mv_data_o} = '0;
        faddr_o = '0;
        sup_o = 1'b1;
    end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        we_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge ref_clk_i);
        we_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        re_o <= 1'b1;
        addr_o <= a;
        @(posedge ref_clk_i);
        re_o <= 1'b0;
        #1 d = rdata_i;
    endtask : rd
    task keys;
        wr(fkw_pkg::KEY_OFS, {24'h0, fkw_pkg::KEY_FIRST});
        wr(fkw_pkg::KEY_OFS, {24'h0, fkw_pkg::KEY_SECOND});
    endtask : keys
    task set_sup(input logic v);
        @(posedge ref_clk_i);
        sup_o <= v;
    endtask : set_sup
    task ft(input logic [fkw_pkg::ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        faddr_o <= a;
        @(posedge ref_clk_i);
        #1 d = fdata_i;
    endtask : ft
    // Move write, then sit out the stall counting its cycles
    task mv(input logic [fkw_pkg::ADDR_W-1:0] a, input logic [7:0] d,
            output int n, output logic e);
        n = 0;
        e = 1'b0;
        @(posedge ref_clk_i);
        mv_o <= 1'b1;
        mv_addr_o <= a;
        mv_data_o <= d;
        @(posedge ref_clk_i);
        mv_o <= 1'b0;
        mv_data_o <= ~d;
        #1;
        repeat (20) begin
            if (stall_i === 1'b1) n++;
            if (err_i === 1'b1) e = 1'b1;
            @(posedge ref_clk_i);
            #1;
        end
    endtask : mv
endmodule : fkw_core_model
`default_nettype wire

// >>> bench/fkw_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fkw_ctrl_tb;
    localparam int PC = 4;
    localparam int EC = 6;
    localparam logic [7:0] ST = fkw_pkg::STAT_OFS;
    localparam logic [7:0] CT = fkw_pkg::CTRL_OFS;
    localparam logic [31:0] SUP = 32'h1 << fkw_pkg::STAT_SUPPLY_BIT;
    localparam logic [31:0] OPN = 32'h1 << fkw_pkg::STAT_OPEN_BIT;
    localparam logic [31:0] DED = 32'h1 << fkw_pkg::STAT_DEAD_BIT;
    localparam logic [31:0] PND = 32'h1 << fkw_pkg::STAT_PEND_BIT;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    wire logic [7:0] ra, md, fd, xd;
    wire logic [31:0] wd, rdat;
    wire logic we, re, mvw, sup, stall, err, xwe;
    wire logic [fkw_pkg::ADDR_W-1:0] ma, fa, xa;
    int n_errors = 0;
    int check_count = 0;
    int n;
    logic e;
    logic [31:0] r;
    logic [7:0] f;
    // Clock
    always #4 ref_clk = ~ref_clk;
    fkw_ctrl #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut (.ref_clk_i(ref_clk),
        .rst_b_i(rst_b), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rdat), .xmove_we_i(mvw),
        .xmove_addr_i(ma), .xmove_data_i(md), .supply_monitor_on_i(sup),
        .fetch_addr_i(fa), .fetch_data_o(fd), .stall_o(stall),
        .flash_error_reset_o(err), .xram_we_o(xwe), .xram_addr_o(xa),
        .xram_data_o(xd));
    fkw_core_model c (.ref_clk_i(ref_clk), .stall_i(stall), .err_i(err),
        .rdata_i(rdat), .fdata_i(fd), .addr_o(ra), .wdata_o(wd), .we_o(we),
        .re_o(re), .mv_o(mvw), .mv_addr_o(ma), .mv_data_o(md), .sup_o(sup),
        .faddr_o(fa));
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task results;
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task do_reset;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask : do_reset
    task t_reset;
        c.rd(ST, r);
        chk(r, SUP);
        c.rd(CT, r);
        chk(r, 32'h0);
        c.rd(8'h0C, r);
        chk(r, 32'h0);
    endtask : t_reset
    task t_erase;
        c.keys();
        c.wr(CT, 32'h3);
        c.mv(13'h0205, 8'h00, n, e);
        chk(32'(n), EC);
        c.ft(13'h0200, f);
        chk({24'h0, f}, 32'hFF);
        c.ft(13'h03FF, f);
        chk({24'h0, f}, 32'hFF);
        c.rd(ST, r);
        chk(r, SUP);
        c.rd(CT, r);
        chk(r, 32'h3);
    endtask : t_erase
    task t_byte;
        c.wr(CT, 32'h1);
        c.keys();
        c.mv(13'h0210, 8'h3C, n, e);
        chk(32'(n), PC);
        c.ft(13'h0210, f);
        chk({24'h0, f}, 32'h3C);
        c.keys();
        c.mv(13'h0210, 8'hF5, n, e);
        chk(32'(n), PC);
        c.ft(13'h0210, f);
        chk({24'h0, f}, 32'h34);
    endtask : t_byte
    task t_block;
        c.wr(CT, 32'h5);
        c.keys();
        c.mv(13'h0220, 8'h12, n, e);
        chk(32'(n), 0);
        c.rd(ST, r);
        chk(r, SUP | PND);
        c.keys();
        c.mv(13'h0221, 8'h34, n, e);
        chk(32'(n), PC);
        c.ft(13'h0220, f);
        chk({24'h0, f}, 32'h12);
        c.ft(13'h0221, f);
        chk({24'h0, f}, 32'h34);
        // Even byte kept as it is by writing all ones
        c.keys();
        c.mv(13'h0222, 8'hFF, n, e);
        c.keys();
        c.mv(13'h0223, 8'h56, n, e);
        chk(32'(n), PC);
        c.ft(13'h0222, f);
        chk({24'h0, f}, 32'hFF);
        c.ft(13'h0223, f);
        chk({24'h0, f}, 32'h56);
    endtask : t_block
    task t_supply;
        c.wr(CT, 32'h0);
        c.mv(13'h0100, 8'h77, n, e);
        chk(32'(n), 0);
        chk({19'h0, xa}, 32'h0100);
        chk({24'h0, xd}, 32'h77);
        c.wr(CT, 32'h1);
        c.keys();
        c.set_sup(1'b0);
        c.mv(13'h0230, 8'h00, n, e);
        chk(32'(e), 32'h1);
        chk(32'(n), 0);
        c.ft(13'h0230, f);
        chk({24'h0, f}, 32'hFF);
        c.rd(ST, r);
        chk(r, OPN);
        c.set_sup(1'b1);
        c.mv(13'h0230, 8'h5A, n, e);
        chk(32'(n), PC);
    endtask : t_supply
    task t_lock;
        c.mv(13'h0240, 8'h00, n, e);
        chk(32'(n), 0);
        c.rd(ST, r);
        chk(r, SUP | DED);
        c.keys();
        c.mv(13'h0240, 8'h00, n, e);
        chk(32'(n), 0);
        c.ft(13'h0240, f);
        chk({24'h0, f}, 32'hFF);
        do_reset();
        c.rd(ST, r);
        chk(r, SUP);
    endtask : t_lock
    task t_key(input logic [7:0] a, input logic [7:0] b, input int gap,
               input logic [31:0] x);
        do_reset();
        c.wr(fkw_pkg::KEY_OFS, {24'h0, a});
        repeat (gap) @(posedge ref_clk);
        c.wr(fkw_pkg::KEY_OFS, {24'h0, b});
        c.rd(ST, r);
        chk(r, x);
    endtask : t_key
    // A code after the keys opened is out of order
    task t_third;
        do_reset();
        c.keys();
        c.rd(ST, r);
        chk(r, SUP | OPN);
        c.wr(fkw_pkg::KEY_OFS, {24'h0, fkw_pkg::KEY_FIRST});
        c.rd(ST, r);
        chk(r, SUP | DED);
    endtask : t_third
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_erase();
        t_byte();
        t_block();
        t_supply();
        t_lock();
        t_key(8'hA5, 8'hF1, 40, SUP | OPN);
        t_key(8'hF1, 8'hA5, 0, SUP | DED);
        t_key(8'hA5, 8'h5A, 0, SUP | DED);
        t_third();
        results();
    end
    // Hang guard
    initial begin
        #400000;
        n_errors++;
        results();
    end
endmodule : fkw_ctrl_tb
`default_nettype wire
